//--- rtl/bmd_decoder.sv
// Decoder for compare-and-branch, control-transfer and memory format words.
// Assumes fetch presents the word, its address, the next word and register
// contents for base and index together, with format class from predecode.
//
// Summary of operation
// (RULE1) Compare-branch opcode is top eight bits
// (RULE2) First source literal when select bit set
// (RULE3) Second source always register; special bit reserved
// (RULE4) Compare-branch displacement signed, sign-extended words
// (RULE5) Target is address plus displacement times four
// (RULE6) Control-transfer opcode is top eight bits
// (RULE7) Extended transfers decode as memory format
// (RULE8) Control-transfer displacement signed, scaled like compare-branch
// (RULE9) Return ignores the displacement field
// (RULE10) Bit 12 selects short or long subform
// (RULE11) Source/destination field names data register group
// (RULE12) Short offset unsigned, never sign-extended
// (RULE13) Short mode 00: address is offset
// (RULE14) Short mode 10: base plus offset
// (RULE15) Long 0100 base; 0111 base plus scaled index
// (RULE16) Long 11xx modes add second-word displacement
// (RULE17) Long 0101: address plus displacement plus eight
// (RULE18) Second word is signed 32-bit displacement
// (RULE19) Long mode 0110 flags invalid opcode
// (RULE20) Scale codes 000-100 multiply by powers two
// (RULE21) Literal operand zero-extended five-bit value
// (RULE22) Codes 0-15 local, 16-31 global registers
// (RULE23) Report instruction length of one or two
// (RULE24) Reserved special-bit encoding flags invalid opcode
`include "bmd_regs.svh"

module bmd_decoder #(
  parameter int WORD_W = `BMD_WORD_W
) (
  // Clock, reset, enable
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  input  wire logic                          clk_en,
  // Fetch side
  input  wire logic                          in_valid,
  output logic                               in_ready,
  input  wire logic [WORD_W-1:0]             in_word,
  input  wire logic [WORD_W-1:0]             in_next_word,
  input  wire logic                          in_next_valid,
  input  wire logic [WORD_W-1:0]             in_ip,
  input  wire bmd_pkg::bmd_fmt_t             in_fmt,
  input  wire logic                          in_ext_xfer,
  input  wire logic                          in_is_ret,
  input  wire logic                          in_is_store,
  // Register contents for address generation
  input  wire logic [WORD_W-1:0]             base_val,
  input  wire logic [WORD_W-1:0]             index_val,
  // Execution side
  output logic                               out_valid,
  output bmd_pkg::bmd_fmt_t                  out_fmt,
  output logic [7:0]                         out_opcode,
  output bmd_pkg::bmd_len_t                  out_len,
  output logic                               out_first_source_field_is_lit,
  output logic [WORD_W-1:0]                  out_first_source_field_lit,
  output logic [`BMD_NUM_OPER*4-1:0]         out_reg_num,
  output logic [`BMD_NUM_OPER-1:0]           out_reg_glob,
  output logic                               out_store_data,
  output logic [WORD_W-1:0]                  out_target,
  output logic                               out_target_valid,
  output logic [WORD_W-1:0]                  out_ea,
  output logic                               out_ea_valid,
  output logic                               out_scale_rsvd,
  output logic                               out_invalid
);

  // Field extraction
  wire logic [7:0]           opcode      = in_word[`BMD_OPC_HI:`BMD_OPC_LO]; // RULE1 RULE6 RULE10
  wire logic [4:0]           fld1        = in_word[`BMD_F1_HI:`BMD_F1_LO];
  wire logic [4:0]           fld2        = in_word[`BMD_F2_HI:`BMD_F2_LO];
  wire logic [4:0]           fld_index   = in_word[`BMD_INDEX_HI:`BMD_INDEX_LO];
  wire logic                 lit_sel     = in_word[`BMD_M1_BIT];
  wire logic                 special_bit = in_word[`BMD_S2_BIT];
  wire logic                 long_sub    = in_word[`BMD_SUBFORM_BIT]; // RULE10
  wire logic                 short_memory_subform_base   = in_word[`BMD_SHORT_MEMORY_SUBFORM_MODE_BIT];
  wire logic [3:0]           long_memory_subform_mode   = in_word[`BMD_LONG_MEMORY_SUBFORM_MODE_HI:`BMD_LONG_MEMORY_SUBFORM_MODE_LO];
  wire logic [2:0]           scale       = in_word[`BMD_SCALE_HI:`BMD_SCALE_LO];
  wire logic [11:0]          offset      = in_word[`BMD_OFFSET_HI:`BMD_OFFSET_LO];

  // Format class; extended transfers arrive flagged and are steered to memory
  wire logic                 is_ctrl     = (in_fmt == bmd_pkg::BMD_FMT_CTRL) && !in_ext_xfer; // RULE7
  wire logic                 is_mem      = (in_fmt == bmd_pkg::BMD_FMT_MEM) || in_ext_xfer; // RULE7
  wire logic                 is_compare_branch_format     = (in_fmt == bmd_pkg::BMD_FMT_COMPARE_BRANCH_FORMAT) && !in_ext_xfer;
  wire bmd_pkg::bmd_fmt_t    fmt_eff     = is_mem ? bmd_pkg::BMD_FMT_MEM : in_fmt;

  // Branch displacements, sign-extended then scaled to bytes
  wire logic [WORD_W-1:0]    compare_branch_format_words  =
    WORD_W'(signed'(in_word[`BMD_COMPARE_BRANCH_FORMAT_DISP_HI:`BMD_COMPARE_BRANCH_FORMAT_DISP_LO])); // RULE4
  wire logic [WORD_W-1:0]    ctrl_words  =
    WORD_W'(signed'(in_word[`BMD_CTRL_DISP_HI:`BMD_CTRL_DISP_LO])); // RULE8
  wire logic [WORD_W-1:0]    br_words    = is_compare_branch_format ? compare_branch_format_words : ctrl_words;
  wire logic [WORD_W-1:0]    br_target   = in_ip + {br_words[WORD_W-3:0], 2'b00}; // RULE5 RULE8
  // Return takes its target from the frame, so the field is dropped
  wire logic                 tgt_ok      = is_compare_branch_format || (is_ctrl && !in_is_ret); // RULE9

  // Memory address generation
  wire logic [WORD_W-1:0]    disp        = in_next_word; // RULE18
  wire logic [WORD_W-1:0]    off_ext     = {{(WORD_W-12){1'b0}}, offset}; // RULE12
  // Reserved scale codes still shift; result is unpredictable by definition
  wire logic [WORD_W-1:0]    scaled_idx  = index_val << scale; // RULE20
  wire logic                 scale_rsvd  = scale > `BMD_SCALE_MAX; // RULE20
  wire logic                 mode_rsvd   = long_sub && (long_memory_subform_mode == `BMD_MODE_RSVD); // RULE19
  wire logic                 uses_index  = long_sub &&
    ((long_memory_subform_mode == `BMD_MODE_RINDX) || (long_memory_subform_mode == `BMD_MODE_IDXDISP) || (long_memory_subform_mode == `BMD_MODE_FULL));
  wire logic                 two_word    = is_mem && long_sub &&
    (long_memory_subform_mode[3] || (long_memory_subform_mode == `BMD_MODE_IPDISP)); // RULE16 RULE17
  wire logic                 second_first_source_field = is_compare_branch_format && special_bit; // RULE3 RULE24

  logic [WORD_W-1:0]         ea_calc;
  always_comb begin
    ea_calc = `BMD_RST_WORD;
    if (!long_sub) begin
      ea_calc = short_memory_subform_base ? base_val + off_ext : off_ext; // RULE13 RULE14
    end else begin
      unique case (long_memory_subform_mode)
        `BMD_MODE_RIND:    ea_calc = base_val; // RULE15
        `BMD_MODE_IPDISP:  ea_calc = in_ip + disp + `BMD_IP_PIPE_ADJ; // RULE17
        `BMD_MODE_RINDX:   ea_calc = base_val + scaled_idx; // RULE15
        `BMD_MODE_ABSDISP: ea_calc = disp; // RULE16
        `BMD_MODE_RDISP:   ea_calc = base_val + disp; // RULE16
        `BMD_MODE_IDXDISP: ea_calc = scaled_idx + disp; // RULE16
        `BMD_MODE_FULL:    ea_calc = base_val + scaled_idx + disp; // RULE16
        default:           ea_calc = `BMD_RST_WORD;
      endcase
    end
  end

  // Handshake: a two-word instruction waits for its displacement word
  wire logic                 take        = in_valid && in_ready;
  assign in_ready = clk_en && (!two_word || in_next_valid); // RULE23

  wire bmd_pkg::bmd_len_t    len_nxt     = two_word ? bmd_pkg::BMD_LEN_TWO : bmd_pkg::BMD_LEN_ONE; // RULE23
  wire logic                 invalid_nxt = (is_mem && mode_rsvd) || second_first_source_field; // RULE19 RULE24
  wire logic                 lit_nxt     = is_compare_branch_format && lit_sel; // RULE2
  wire logic [WORD_W-1:0]    lit_val_nxt = {{(WORD_W-`BMD_LIT_W){1'b0}}, fld1}; // RULE21

  // Operand selectors: first_source_field, second_source_field, src/dst, abase, index
  wire logic [4:0]           oper_code [`BMD_NUM_OPER];
  assign oper_code[0] = fld1;
  assign oper_code[1] = fld2; // RULE3
  assign oper_code[2] = fld1; // RULE11
  assign oper_code[3] = fld2;
  assign oper_code[4] = fld_index;

  logic [`BMD_NUM_OPER*4-1:0] reg_num_nxt;
  logic [`BMD_NUM_OPER-1:0]   reg_glob_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < `BMD_NUM_OPER; gi++) begin : g_oper
      assign reg_num_nxt[gi*4 +: 4] = oper_code[gi][3:0]; // RULE22
      assign reg_glob_nxt[gi]       = oper_code[gi][4]; // RULE22
    end
  endgenerate

  // Output registers
  logic                      valid_r;
  bmd_pkg::bmd_fmt_t         fmt_r;
  logic [7:0]                opcode_r;
  bmd_pkg::bmd_len_t         len_r;
  logic                      lit_r;
  logic [WORD_W-1:0]         lit_val_r;
  logic [`BMD_NUM_OPER*4-1:0] reg_num_r;
  logic [`BMD_NUM_OPER-1:0]  reg_glob_r;
  logic                      store_r;
  logic [WORD_W-1:0]         target_r;
  logic                      target_ok_r;
  logic [WORD_W-1:0]         ea_r;
  logic                      ea_ok_r;
  logic                      scale_rsvd_r;
  logic                      invalid_r;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      valid_r <= 1'b0;
    end else if (clk_en) begin
      valid_r <= take;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fmt_r        <= bmd_pkg::BMD_FMT_OTHER;
      opcode_r     <= `BMD_RST_BYTE;
      len_r        <= bmd_pkg::BMD_LEN_NONE;
      lit_r        <= 1'b0;
      lit_val_r    <= `BMD_RST_WORD;
      reg_num_r    <= '0;
      reg_glob_r   <= '0;
      store_r      <= 1'b0;
    end else if (clk_en && take) begin
      fmt_r        <= fmt_eff;
      opcode_r     <= opcode;
      len_r        <= len_nxt;
      lit_r        <= lit_nxt;
      lit_val_r    <= lit_val_nxt;
      reg_num_r    <= reg_num_nxt;
      reg_glob_r   <= reg_glob_nxt;
      store_r      <= is_mem && in_is_store; // RULE11
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      target_r     <= `BMD_RST_WORD;
      target_ok_r  <= 1'b0;
      ea_r         <= `BMD_RST_WORD;
      ea_ok_r      <= 1'b0;
      scale_rsvd_r <= 1'b0;
      invalid_r    <= 1'b0;
    end else if (clk_en && take) begin
      target_r     <= tgt_ok ? br_target : in_ip; // RULE9
      target_ok_r  <= tgt_ok;
      ea_r         <= is_mem ? ea_calc : `BMD_RST_WORD;
      ea_ok_r      <= is_mem && !mode_rsvd; // RULE19
      scale_rsvd_r <= is_mem && uses_index && scale_rsvd; // RULE20
      invalid_r    <= invalid_nxt;
    end
  end

  assign out_valid        = valid_r;
  assign out_fmt          = fmt_r;
  assign out_opcode       = opcode_r;
  assign out_len          = len_r;
  assign out_first_source_field_is_lit  = lit_r;
  assign out_first_source_field_lit     = lit_val_r;
  assign out_reg_num      = reg_num_r;
  assign out_reg_glob     = reg_glob_r;
  assign out_store_data   = store_r;
  assign out_target       = target_r;
  assign out_target_valid = target_ok_r;
  assign out_ea           = ea_r;
  assign out_ea_valid     = ea_ok_r;
  assign out_scale_rsvd   = scale_rsvd_r;
  assign out_invalid      = invalid_r;

  // Checks

  sequence s_take;
    clk_en && in_valid && in_ready;
  endsequence

  sequence s_take_compare_branch_format;
    s_take ##0 (in_fmt == bmd_pkg::BMD_FMT_COMPARE_BRANCH_FORMAT) && !in_ext_xfer;
  endsequence

  sequence s_take_ctrl_br;
    s_take ##0 (in_fmt == bmd_pkg::BMD_FMT_CTRL) && !in_ext_xfer && !in_is_ret;
  endsequence

  sequence s_take_mem;
    s_take ##0 ((in_fmt == bmd_pkg::BMD_FMT_MEM) || in_ext_xfer);
  endsequence

  AST_OPCODE_TOP: assert property (@(posedge core_clk) disable iff (!rstn) // RULE1
    s_take |=> out_valid && (out_opcode == $past(in_word[31:24])))
    else $error("opcode not taken from top byte");

  AST_COMPARE_BRANCH_FORMAT_LIT: assert property (@(posedge core_clk) disable iff (!rstn) // RULE2
    s_take_compare_branch_format ##0 in_word[13] |=> out_first_source_field_is_lit && (out_first_source_field_lit == {27'h000_0000, $past(in_word[23:19])}))
    else $error("compare-branch literal not zero-extended");

  AST_COMPARE_BRANCH_FORMAT_RSVD: assert property (@(posedge core_clk) disable iff (!rstn) // RULE24
    s_take_compare_branch_format |=> (out_invalid == $past(in_word[0])))
    else $error("reserved special bit not flagged");

  AST_COMPARE_BRANCH_FORMAT_TARGET: assert property (@(posedge core_clk) disable iff (!rstn) // RULE5
    s_take_compare_branch_format |=> out_target_valid &&
      (out_target == $past(in_ip) + {{19{$past(in_word[12])}}, $past(in_word[12:2]), 2'b00}))
    else $error("compare-branch target wrong");

  AST_CTRL_TARGET: assert property (@(posedge core_clk) disable iff (!rstn) // RULE8
    s_take_ctrl_br |=> out_target_valid &&
      (out_target == $past(in_ip) + {{8{$past(in_word[23])}}, $past(in_word[23:2]), 2'b00}))
    else $error("control-transfer target wrong");

  AST_RET_NO_TARGET: assert property (@(posedge core_clk) disable iff (!rstn) // RULE9
    s_take ##0 (in_fmt == bmd_pkg::BMD_FMT_CTRL) && in_is_ret && !in_ext_xfer
      |=> !out_target_valid && (out_target == $past(in_ip)))
    else $error("return used its displacement");

  AST_EXT_AS_MEM: assert property (@(posedge core_clk) disable iff (!rstn) // RULE7
    s_take ##0 in_ext_xfer |=> (out_fmt == bmd_pkg::BMD_FMT_MEM) && !out_target_valid)
    else $error("extended transfer not decoded as memory");

  AST_SHORT_MEMORY_SUBFORM_ABS: assert property (@(posedge core_clk) disable iff (!rstn) // RULE13
    s_take_mem ##0 !in_word[12] && !in_word[13] |=> out_ea == {20'h0_0000, $past(in_word[11:0])})
    else $error("absolute offset address wrong");

  AST_SHORT_MEMORY_SUBFORM_BASE: assert property (@(posedge core_clk) disable iff (!rstn) // RULE14
    s_take_mem ##0 !in_word[12] && in_word[13] |=> out_ea == $past(base_val) + {20'h0_0000, $past(in_word[11:0])})
    else $error("base plus offset address wrong");

  AST_IP_DISP: assert property (@(posedge core_clk) disable iff (!rstn) // RULE17
    s_take_mem ##0 in_word[12] && (in_word[13:10] == 4'h5)
      |=> (out_len == bmd_pkg::BMD_LEN_TWO) && (out_ea == $past(in_ip) + $past(in_next_word) + 32'h0000_0008))
    else $error("address plus displacement mode wrong");

  AST_FULL_MODE: assert property (@(posedge core_clk) disable iff (!rstn) // RULE16
    s_take_mem ##0 in_word[12] && (in_word[13:10] == 4'hF)
      |=> out_ea == $past(base_val) + ($past(index_val) << $past(in_word[9:7])) + $past(in_next_word))
    else $error("full indexed mode wrong");

  AST_MODE_RSVD: assert property (@(posedge core_clk) disable iff (!rstn) // RULE19
    s_take_mem ##0 in_word[12] && (in_word[13:10] == 4'h6) |=> out_invalid && !out_ea_valid)
    else $error("reserved mode not flagged");

  AST_TWO_WORD_WAIT: assert property (@(posedge core_clk) disable iff (!rstn) // RULE23
    clk_en && in_valid && !in_next_valid && ((in_fmt == bmd_pkg::BMD_FMT_MEM) || in_ext_xfer)
      && in_word[12] && in_word[13] |-> !in_ready)
    else $error("two-word instruction taken without displacement");

  AST_REG_MAP: assert property (@(posedge core_clk) disable iff (!rstn) // RULE22
    s_take |=> (out_reg_glob[1] == $past(in_word[18])) && (out_reg_num[7:4] == $past(in_word[17:14])))
    else $error("register code mapping wrong");

  AST_RIND: assert property (@(posedge core_clk) disable iff (!rstn) // RULE15
    s_take_mem ##0 in_word[12] && (in_word[13:10] == 4'h4)
      |=> (out_len == bmd_pkg::BMD_LEN_ONE) && out_ea_valid && (out_ea == $past(base_val)))
    else $error("register indirect mode wrong");

  AST_RINDX: assert property (@(posedge core_clk) disable iff (!rstn) // RULE15
    s_take_mem ##0 in_word[12] && (in_word[13:10] == 4'h7)
      |=> (out_len == bmd_pkg::BMD_LEN_ONE) &&
        (out_ea == $past(base_val) + ($past(index_val) << $past(in_word[9:7]))))
    else $error("register indirect with index mode wrong");

  AST_ABS_DISP: assert property (@(posedge core_clk) disable iff (!rstn) // RULE18
    s_take_mem ##0 in_word[12] && (in_word[13:10] == 4'hC)
      |=> (out_len == bmd_pkg::BMD_LEN_TWO) && (out_ea == $past(in_next_word)))
    else $error("absolute displacement mode wrong");

  AST_SCALE_FLAG: assert property (@(posedge core_clk) disable iff (!rstn) // RULE20
    s_take_mem ##0 in_word[12] && (in_word[13:10] == 4'h7)
      |=> out_scale_rsvd == ($past(in_word[9:7]) > 3'h4))
    else $error("reserved scale flag wrong");

  AST_STORE_GROUP: assert property (@(posedge core_clk) disable iff (!rstn) // RULE11
    s_take_mem |=> out_store_data == $past(in_is_store))
    else $error("store data group flag wrong");

  AST_VALID_PULSE: assert property (@(posedge core_clk) disable iff (!rstn) // RULE23
    clk_en && !(in_valid && in_ready) |=> !out_valid)
    else $error("output valid without a take");

  // Frozen cycles must not leak a half-updated decode
  AST_FREEZE: assert property (@(posedge core_clk) disable iff (!rstn)
    !clk_en |=> $stable(out_valid) && $stable(out_target) && $stable(out_ea))
    else $error("outputs moved while clock enable low");

  AST_RESET_IDLE: assert property (@(posedge core_clk)
    !rstn |=> !out_valid && (out_fmt == bmd_pkg::BMD_FMT_OTHER) && (out_len == bmd_pkg::BMD_LEN_NONE)
      && !out_invalid)
    else $error("outputs not idle after reset");

endmodule // bmd_decoder

//--- rtl/bmd_regs.svh
// Field positions, mode codes and constants of the branch/memory format decoder.
// Assumes a 32-bit instruction word with bit 31 as the most significant bit.
`ifndef BMD_REGS_SVH
`define BMD_REGS_SVH

`define BMD_WORD_W        32
`define BMD_OPC_HI        31
`define BMD_OPC_LO        24
`define BMD_F1_HI         23
`define BMD_F1_LO         19
`define BMD_F2_HI         18
`define BMD_F2_LO         14
`define BMD_M1_BIT        13
`define BMD_S2_BIT        0
`define BMD_COMPARE_BRANCH_FORMAT_DISP_HI  12
`define BMD_COMPARE_BRANCH_FORMAT_DISP_LO  2
`define BMD_CTRL_DISP_HI  23
`define BMD_CTRL_DISP_LO  2
`define BMD_SUBFORM_BIT   12
`define BMD_SHORT_MEMORY_SUBFORM_MODE_BIT 13
`define BMD_OFFSET_HI     11
`define BMD_OFFSET_LO     0
`define BMD_LONG_MEMORY_SUBFORM_MODE_HI  13
`define BMD_LONG_MEMORY_SUBFORM_MODE_LO  10
`define BMD_SCALE_HI      9
`define BMD_SCALE_LO      7
`define BMD_INDEX_HI      4
`define BMD_INDEX_LO      0
`define BMD_LIT_W         5
`define BMD_NUM_OPER      5
`define BMD_MODE_RIND     4'h4
`define BMD_MODE_IPDISP   4'h5
`define BMD_MODE_RSVD     4'h6
`define BMD_MODE_RINDX    4'h7
`define BMD_MODE_ABSDISP  4'hC
`define BMD_MODE_RDISP    4'hD
`define BMD_MODE_IDXDISP  4'hE
`define BMD_MODE_FULL     4'hF
`define BMD_SCALE_MAX     3'h4
`define BMD_IP_PIPE_ADJ   32'h0000_0008
`define BMD_RST_WORD      32'h0000_0000
`define BMD_RST_BYTE      8'h00

`endif

//--- rtl/bmd_pkg.sv
// Types shared by the branch/memory format decoder.
// Assumes the format class comes from the opcode predecode in fetch.
package bmd_pkg;

  typedef enum logic [1:0] {
    BMD_FMT_CTRL,
    BMD_FMT_COMPARE_BRANCH_FORMAT,
    BMD_FMT_MEM,
    BMD_FMT_OTHER
  } bmd_fmt_t;

  typedef enum logic [1:0] {
    BMD_LEN_NONE,
    BMD_LEN_ONE,
    BMD_LEN_TWO
  } bmd_len_t;

endpackage

//--- dv/bmd_regfile_model.sv
// Register-file side partner of the decoder: supplies base and index contents.
// Assumes the bench presents the instruction word; contents follow its fields.
module bmd_regs_model (
  // Instruction word from fetch
  input  wire logic [31:0] in_word,
  // Register contents toward the decoder
  output logic [31:0]      base_val,
  output logic [31:0]      index_val
);
  timeunit 1ns;
  timeprecision 100ps;
  // Distinct contents per code so a wrong field pick changes the sum
  assign base_val  = {8'h40, 11'h000, in_word[18:14], 8'h00};
  assign index_val = {27'h000_0000, in_word[4:0]} + 32'h0000_0003;
endmodule // bmd_regs_model

//--- dv/tb_top.sv
// Self-checking bench of the branch/memory format decoder.
// Assumes the register model answers combinationally from the presented word.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    bmd_pkg::bmd_fmt_t fmt;
    logic ext, ret, st;
    logic [31:0] word, nxt, ip;
    logic [4:0] terms;
    logic [31:0] tgt;
    logic tv, inv;
    bmd_pkg::bmd_len_t len;
  } bmd_row_t;
  // Terms: offset, ip plus eight, displacement, scaled index, base
  bmd_row_t rows[14] = '{
    '{bmd_pkg::BMD_FMT_COMPARE_BRANCH_FORMAT,0,0,0,32'h3000_1FFC,0,32'h0000_1000,5'h00,32'h0000_0FFC,1,0,bmd_pkg::BMD_LEN_ONE},
    '{bmd_pkg::BMD_FMT_COMPARE_BRANCH_FORMAT,0,0,0,32'h32F8_2FFD,0,32'h0000_1000,5'h00,32'h0000_1FFC,1,1,bmd_pkg::BMD_LEN_ONE},
    '{bmd_pkg::BMD_FMT_CTRL,0,0,0,32'h0880_0000,0,32'h0100_0000,5'h00,32'h0080_0000,1,0,bmd_pkg::BMD_LEN_ONE},
    '{bmd_pkg::BMD_FMT_CTRL,0,1,0,32'h0A00_0FFC,0,32'h0000_2000,5'h00,0,0,0,bmd_pkg::BMD_LEN_ONE},
    '{bmd_pkg::BMD_FMT_MEM,0,0,1,32'h8C80_4FFF,0,32'h0000_3000,5'h10,0,0,0,bmd_pkg::BMD_LEN_ONE},
    '{bmd_pkg::BMD_FMT_MEM,0,0,0,32'h8C80_6FFF,0,32'h0000_3000,5'h11,0,0,0,bmd_pkg::BMD_LEN_ONE},
    '{bmd_pkg::BMD_FMT_MEM,0,0,0,32'h8C00_5000,0,32'h0000_3000,5'h01,0,0,0,bmd_pkg::BMD_LEN_ONE},
    '{bmd_pkg::BMD_FMT_MEM,0,0,0,32'h8C00_9E03,0,32'h0000_3000,5'h03,0,0,0,bmd_pkg::BMD_LEN_ONE},
    '{bmd_pkg::BMD_FMT_MEM,0,0,0,32'h8C00_1400,32'hFFFF_FFF0,32'h0000_4000,5'h0C,0,0,0,bmd_pkg::BMD_LEN_TWO},
    '{bmd_pkg::BMD_FMT_MEM,0,0,0,32'h8C00_3000,32'h1234_5678,32'h0000_4000,5'h04,0,0,0,bmd_pkg::BMD_LEN_TWO},
    '{bmd_pkg::BMD_FMT_MEM,0,0,0,32'h8C00_F400,32'h8000_0000,32'h0000_4000,5'h05,0,0,0,bmd_pkg::BMD_LEN_TWO},
    '{bmd_pkg::BMD_FMT_MEM,0,0,0,32'h8C00_399F,32'h0000_0100,32'h0000_4000,5'h06,0,0,0,bmd_pkg::BMD_LEN_TWO},
    '{bmd_pkg::BMD_FMT_MEM,0,0,0,32'h8C00_7C05,32'hFFFF_0000,32'h0000_4000,5'h07,0,0,0,bmd_pkg::BMD_LEN_TWO},
    '{bmd_pkg::BMD_FMT_CTRL,1,0,0,32'h8600_5000,0,32'h0000_5000,5'h01,0,0,0,bmd_pkg::BMD_LEN_ONE}
  };
  logic core_clk = 0, rstn = 0, clk_en = 1, in_valid = 0, in_next_valid = 1;
  logic in_ext_xfer = 0, in_is_ret = 0, in_is_store = 0;
  logic [31:0] in_word = '0, in_next_word = '0, in_ip = '0, base_val, index_val, bv, iv, ea;
  bmd_pkg::bmd_fmt_t in_fmt = bmd_pkg::BMD_FMT_OTHER, out_fmt;
  bmd_pkg::bmd_len_t out_len;
  logic in_ready, out_valid, out_first_source_field_is_lit, out_store_data, out_target_valid, out_ea_valid;
  logic out_scale_rsvd, out_invalid;
  logic [7:0] out_opcode;
  logic [31:0] out_first_source_field_lit, out_target, out_ea;
  logic [19:0] out_reg_num;
  logic [4:0] out_reg_glob;
  int fails = 0, checks = 0;
  logic mem;
  always #2 core_clk = ~core_clk;
  bmd_regs_model regs_u (.in_word(in_word), .base_val(base_val), .index_val(index_val));
  bmd_decoder dut_u (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .in_valid(in_valid),
    .in_ready(in_ready), .in_word(in_word), .in_next_word(in_next_word), .in_next_valid(in_next_valid),
    .in_ip(in_ip), .in_fmt(in_fmt), .in_ext_xfer(in_ext_xfer), .in_is_ret(in_is_ret),
    .in_is_store(in_is_store), .base_val(base_val), .index_val(index_val), .out_valid(out_valid),
    .out_fmt(out_fmt), .out_opcode(out_opcode), .out_len(out_len), .out_first_source_field_is_lit(out_first_source_field_is_lit),
    .out_first_source_field_lit(out_first_source_field_lit), .out_reg_num(out_reg_num), .out_reg_glob(out_reg_glob),
    .out_store_data(out_store_data), .out_target(out_target), .out_target_valid(out_target_valid),
    .out_ea(out_ea), .out_ea_valid(out_ea_valid), .out_scale_rsvd(out_scale_rsvd), .out_invalid(out_invalid));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic put(input bmd_row_t r);
    @(negedge core_clk);
    in_valid = 1'b1;
    in_fmt = r.fmt;
    {in_ext_xfer, in_is_ret, in_is_store} = {r.ext, r.ret, r.st};
    {in_word, in_next_word, in_ip} = {r.word, r.nxt, r.ip};
  endtask
  task automatic take(input bmd_row_t r);
    put(r);
    // Let ready and the register model settle on the new word
    #1;
    chk(in_ready, 1);
    bv = base_val;
    iv = index_val;
    @(posedge core_clk);
    #1;
    mem = r.ext || r.fmt == bmd_pkg::BMD_FMT_MEM;
    ea = (r.terms[0] ? bv : '0) + (r.terms[1] ? iv << r.word[9:7] : '0) + (r.terms[2] ? r.nxt : '0)
       + (r.terms[3] ? r.ip + 32'h0000_0008 : '0) + (r.terms[4] ? {20'h0_0000, r.word[11:0]} : '0);
    chk(out_valid, 1);
    chk(out_opcode, r.word[31:24]);
    chk(out_fmt, r.ext ? bmd_pkg::BMD_FMT_MEM : r.fmt);
    chk(out_target, r.tv ? r.tgt : r.ip);
    chk(out_target_valid, r.tv);
    chk(out_ea, mem ? ea : '0);
    chk(out_ea_valid, mem && !r.inv);
    chk(out_scale_rsvd, 0);
    chk(out_first_source_field_is_lit, r.fmt == bmd_pkg::BMD_FMT_COMPARE_BRANCH_FORMAT && !r.ext && r.word[13]);
    chk(out_reg_num, {r.word[3:0], r.word[17:14], r.word[22:19], r.word[17:14], r.word[22:19]});
    chk(out_reg_glob, {r.word[4], r.word[18], r.word[23], r.word[18], r.word[23]});
    chk(out_len, r.len);
    chk(out_invalid, r.inv);
    chk(out_store_data, r.st);
  endtask
  initial begin
    #40000;
    fails++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1;
    // Back-to-back takes through the table
    foreach (rows[i]) take(rows[i]);
    put(rows[1]);
    @(posedge core_clk);
    #1;
    chk(out_first_source_field_is_lit, 1);
    chk(out_first_source_field_lit, 32'h0000_001F);
    chk({out_reg_glob[0], out_reg_num[3:0]}, 5'h1F);
    // Two-word mode without its second word is held off
    put(rows[9]);
    in_next_valid = 0;
    #1;
    chk(in_ready, 0);
    @(negedge core_clk);
    in_valid = 0;
    in_next_valid = 1;
    chk(out_valid, 0);
    clk_en = 0;
    #1;
    chk(in_ready, 0);
    clk_en = 1;
    // Reserved long mode and reserved scale
    take('{bmd_pkg::BMD_FMT_MEM,0,0,0,32'h8C00_1800,0,32'h0000_6000,5'h00,0,0,1,bmd_pkg::BMD_LEN_ONE});
    put('{bmd_pkg::BMD_FMT_MEM,0,0,0,32'h8C00_5F83,0,32'h0000_6000,5'h00,0,0,0,bmd_pkg::BMD_LEN_ONE});
    @(posedge core_clk);
    #1;
    chk(out_scale_rsvd, 1);
    chk(out_invalid, 0);
    // Second reset in mid-run
    @(negedge core_clk);
    {rstn, in_valid} = 2'b00;
    @(posedge core_clk);
    #1;
    chk(out_valid, 0);
    chk(out_fmt, bmd_pkg::BMD_FMT_OTHER);
    chk(out_len, bmd_pkg::BMD_LEN_NONE);
    chk(out_ea, '0);
    @(negedge core_clk);
    rstn = 1;
    // First take after release, then a frozen cycle with a new word waiting
    take(rows[0]);
    put(rows[2]);
    clk_en = 0;
    @(posedge core_clk);
    #1;
    chk(out_valid, 1);
    chk(out_target, rows[0].tgt);
    @(negedge core_clk);
    clk_en = 1;
    @(posedge core_clk);
    #1;
    chk(out_target, rows[2].tgt);
    final_report();
  end
endmodule // tb_top
